// ==== hw/mopc_defs.vh ====
`ifndef MOPC_DEFS_VH
`define MOPC_DEFS_VH
// analog mode codes {hold, run}
`define MOPC_AM_IC      2'h0
`define MOPC_AM_OP      2'h1
`define MOPC_AM_HOLD    2'h2
// logic mode codes {halt, run}
`define MOPC_LM_LOAD    2'h0
`define MOPC_LM_RUN     2'h1
`define MOPC_LM_STOP    2'h2
// reset values
`define MOPC_AM_RESET   2'h0
`define MOPC_LM_RESET   2'h0
`define MOPC_TS_RESET   2'h0
`endif

// ==== hw/mopc_integ_ctl.v ====
`include "mopc_defs.vh"
// ----------------------------------------------------------------
// per-integrator mode resolution
// ----------------------------------------------------------------
module mopc_integ_ctl #(
    parameter N_INTEG = 4
) (
    input  wire [N_INTEG-1:0] hold_drv,
    input  wire [N_INTEG-1:0] hold_val,
    input  wire [N_INTEG-1:0] run_drv,
    input  wire [N_INTEG-1:0] run_val,
    input  wire [1:0]         console_mode,
    input  wire               freeze,
    output reg  [N_INTEG-1:0] integ_hold,
    output reg  [N_INTEG-1:0] integ_run
);
    integer i;
    reg     h;
    reg     r;
    always @*
    begin
        integ_hold = {N_INTEG{1'b0}};
        integ_run  = {N_INTEG{1'b0}};
        h = 1'b0;
        r = 1'b0;
        for (i = 0; i < N_INTEG; i = i + 1)
        begin
            // undriven controls keep the console value
            h = hold_drv[i] ? hold_val[i] : console_mode[1];
            r = run_drv[i]  ? run_val[i]  : console_mode[0];
            if (freeze)
            begin
                integ_hold[i] = 1'b1;
                integ_run[i]  = 1'b0;
            end
            else if (h)
            begin
                integ_hold[i] = 1'b1;
                integ_run[i]  = 1'b0;
            end
            else
            begin
                integ_hold[i] = 1'b0;
                integ_run[i]  = r;
            end
        end
    end
endmodule // mopc_integ_ctl

// ==== hw/mopc_mode_ctl.v ====
`include "mopc_defs.vh"
module mopc_mode_ctl #(
    parameter N_INTEG = 4
) (
    input  wire               clk,
    input  wire               rst_n,
    // panel, timer and host sources
    input  wire [1:0]         panel_analog_mode,
    input  wire [1:0]         timer_analog_mode,
    input  wire               timer_driven_execution,
    input  wire               host_analog_valid,
    input  wire [1:0]         host_analog_mode,
    input  wire [1:0]         sys_logic_mode_in,
    input  wire               overload_in,
    input  wire               autohold_button,
    input  wire               stop_button,
    // console patched controls
    input  wire               console_mode_override_en,
    input  wire               console_master_freeze_in,
    input  wire               console_hold_in,
    input  wire               console_run_in,
    input  wire               console_logic_override_en,
    input  wire               console_halt_in,
    input  wire               console_logic_run_in,
    input  wire               console_tscale_override_en,
    input  wire [1:0]         sys_tscale_in,
    input  wire [1:0]         console_tscale_in,
    // per-integrator patched controls
    input  wire [N_INTEG-1:0] integ_hold_drv,
    input  wire [N_INTEG-1:0] integ_hold_val,
    input  wire [N_INTEG-1:0] integ_run_drv,
    input  wire [N_INTEG-1:0] integ_run_val,
    // outputs
    output reg                sys_hold_out,
    output reg                sys_run_out,
    output reg                sys_freeze_out,
    output reg                sys_logic_halt_out,
    output reg                sys_logic_run_out,
    output reg  [1:0]         ind_analog_mode,
    output reg  [1:0]         ind_logic_mode,
    output reg  [1:0]         ind_tscale,
    output reg                console_freeze_out,
    output reg  [N_INTEG-1:0] integ_hold_out,
    output reg  [N_INTEG-1:0] integ_run_out
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // hold-first decode of a two-bit patched pair
    function [1:0] mopc_decode;
        input hi;
        input lo;
        begin
            if (hi)
                mopc_decode = 2'h2;
            else if (lo)
                mopc_decode = 2'h1;
            else
                mopc_decode = 2'h0;
        end
    endfunction

    // illegal 11 code folds to hold/stop
    function [1:0] mopc_clean;
        input [1:0] m;
        begin
            mopc_clean = m[1] ? 2'h2 : m;
        end
    endfunction

    // ------------------------------------------------------------
    // system level resolution
    // ------------------------------------------------------------
    // source codes for the system analog mode
    localparam SRC_PANEL = 2'h0;
    localparam SRC_TIMER = 2'h1;
    localparam SRC_HOST  = 2'h2;

    reg  [1:0]         sys_src;
    reg  [1:0]         sys_analog;
    reg  [1:0]         sys_logic;
    reg  [1:0]         console_analog;
    reg  [1:0]         console_logic;
    reg  [1:0]         tscale;
    reg                console_freeze_request;
    reg                overload_freeze;
    reg                stop_freeze;
    reg                panel_freeze;
    reg                freeze;
    reg  [1:0]         ind_analog_next;
    wire [N_INTEG-1:0] ih;
    wire [N_INTEG-1:0] ir;

    // host above timer, timer above panel
    always @*
    begin
        if (host_analog_valid)
        begin
            sys_src = SRC_HOST;
        end
        else if (timer_driven_execution)
        begin
            sys_src = SRC_TIMER;
        end
        else
        begin
            sys_src = SRC_PANEL;
        end
    end

    always @*
    begin
        case (sys_src)
            SRC_HOST:
            begin
                sys_analog = mopc_clean(host_analog_mode);
            end
            SRC_TIMER:
            begin
                sys_analog = mopc_clean(timer_analog_mode);
            end
            SRC_PANEL:
            begin
                sys_analog = mopc_clean(panel_analog_mode);
            end
            default:
            begin
                sys_analog = `MOPC_AM_HOLD;
            end
        endcase
    end

    always @*
    begin
        sys_logic = mopc_clean(sys_logic_mode_in);
    end

    // ------------------------------------------------------------
    // console level, downstream of system
    // ------------------------------------------------------------
    // unpatched console inputs arrive as junk from the patch side
    always @*
    begin
        if (console_mode_override_en)
        begin
            console_analog = mopc_decode(console_hold_in,
                                         console_run_in);
        end
        else
        begin
            console_analog = sys_analog;
        end
    end

    always @*
    begin
        if (console_logic_override_en)
        begin
            console_logic = mopc_decode(console_halt_in,
                                        console_logic_run_in);
        end
        else
        begin
            console_logic = sys_logic;
        end
    end

    always @*
    begin
        if (console_tscale_override_en)
        begin
            tscale = console_tscale_in;
        end
        else
        begin
            tscale = sys_tscale_in;
        end
    end

    // ------------------------------------------------------------
    // master hold sources
    // ------------------------------------------------------------
    always @*
    begin
        console_freeze_request = console_mode_override_en &
                                 console_master_freeze_in;
        overload_freeze        = overload_in & autohold_button;
        stop_freeze            = stop_button & timer_driven_execution;
        if (console_mode_override_en)
        begin
            // panel sources have no say under override
            panel_freeze = 1'b0;
        end
        else
        begin
            panel_freeze = overload_freeze | stop_freeze;
        end
        freeze = console_freeze_request | panel_freeze;
    end

    // master hold shows as hold on the console indicator
    always @*
    begin
        if (freeze)
        begin
            ind_analog_next = `MOPC_AM_HOLD;
        end
        else
        begin
            ind_analog_next = console_analog;
        end
    end

    // ------------------------------------------------------------
    // individual integrators
    // ------------------------------------------------------------
    mopc_integ_ctl #(
        .N_INTEG (N_INTEG)
    ) u_integ (
        .hold_drv     (integ_hold_drv),
        .hold_val     (integ_hold_val),
        .run_drv      (integ_run_drv),
        .run_val      (integ_run_val),
        .console_mode (console_analog),
        .freeze       (freeze),
        .integ_hold   (ih),
        .integ_run    (ir)
    );

    // ------------------------------------------------------------
    // system mode output registers
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            sys_hold_out       <= 1'b0;
            sys_run_out        <= 1'b0;
            sys_logic_halt_out <= 1'b0;
            sys_logic_run_out  <= 1'b0;
        end
        else
        begin
            sys_hold_out       <= sys_analog[1];
            sys_run_out        <= sys_analog[0];
            sys_logic_halt_out <= sys_logic[1];
            sys_logic_run_out  <= sys_logic[0];
        end
    end

    // ------------------------------------------------------------
    // master hold flag registers
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            sys_freeze_out     <= 1'b0;
            console_freeze_out <= 1'b0;
        end
        else
        begin
            sys_freeze_out     <= freeze;
            console_freeze_out <= freeze;
        end
    end

    // ------------------------------------------------------------
    // indicator registers
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            ind_analog_mode <= `MOPC_AM_RESET;
            ind_logic_mode  <= `MOPC_LM_RESET;
            ind_tscale      <= `MOPC_TS_RESET;
        end
        else
        begin
            ind_analog_mode <= ind_analog_next;
            ind_logic_mode  <= console_logic;
            ind_tscale      <= tscale;
        end
    end

    // ------------------------------------------------------------
    // integrator mode registers
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            integ_hold_out <= {N_INTEG{1'b0}};
            integ_run_out  <= {N_INTEG{1'b0}};
        end
        else
        begin
            integ_hold_out <= ih;
            integ_run_out  <= ir;
        end
    end
endmodule // mopc_mode_ctl

// ==== bench/mopc_mode_ctl_checker.sv ====
module mopc_mode_ctl_checker #(parameter N_INTEG = 4) (
    input wire logic clk, rst_n, host_analog_valid,
    input wire logic [1:0] host_analog_mode, sys_logic_mode_in,
    input wire logic console_mode_override_en, console_master_freeze_in,
    input wire logic console_hold_in, console_run_in,
    input wire logic console_logic_override_en, console_halt_in,
    input wire logic console_logic_run_in, sys_hold_out, sys_run_out,
    input wire logic sys_freeze_out, console_freeze_out,
    input wire logic sys_logic_halt_out, sys_logic_run_out,
    input wire logic [1:0] ind_analog_mode, ind_logic_mode,
    input wire logic [N_INTEG-1:0] integ_hold_out, integ_run_out
);
    function automatic logic [1:0] fld(logic [1:0] m);
        return m[1] ? 2'h2 : m;
    endfunction
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_host_sys_mode: assert property (host_analog_valid &&
        !host_analog_mode[1] |=> {sys_hold_out, sys_run_out} ==
        $past(host_analog_mode)) else $error("host mode");
    a_sys_logic_code: assert property (1'b1 |=>
        {sys_logic_halt_out, sys_logic_run_out} ==
        fld($past(sys_logic_mode_in))) else $error("logic code");
    a_console_freeze: assert property (console_mode_override_en &&
        console_master_freeze_in |=> sys_freeze_out && console_freeze_out)
        else $error("freeze");
    a_override_blocks: assert property (console_mode_override_en &&
        !console_master_freeze_in |=> !sys_freeze_out) else $error("block");
    a_console_hold: assert property (console_mode_override_en &&
        console_hold_in |=> ind_analog_mode == 2'h2) else $error("hold");
    a_console_run: assert property (console_mode_override_en &&
        !console_hold_in && !console_master_freeze_in |=>
        ind_analog_mode == {1'b0, $past(console_run_in)}) else $error("run");
    a_freeze_integ: assert property (sys_freeze_out |->
        &integ_hold_out && integ_run_out == '0) else $error("integ");
    a_logic_override: assert property (console_logic_override_en |=>
        ind_logic_mode == fld({$past(console_halt_in),
        $past(console_logic_run_in)})) else $error("logic override");
    cover property (console_mode_override_en && console_master_freeze_in);
    cover property (sys_freeze_out && !console_mode_override_en);
    cover property (console_logic_override_en && console_halt_in);
endmodule // mopc_mode_ctl_checker
bind mopc_mode_ctl mopc_mode_ctl_checker #(.N_INTEG(N_INTEG)) u_chk (.*);

// ==== bench/mopc_patch_model.sv ====
module mopc_patch_model #(parameter N_INTEG = 4) (
    input wire logic clk,
    output logic console_mode_override_en, console_master_freeze_in,
    output logic console_hold_in, console_run_in,
    output logic [N_INTEG-1:0] integ_hold_drv, integ_hold_val,
    output logic [N_INTEG-1:0] integ_run_drv, integ_run_val
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [19:0] pv = '0;
    // unpatched integrator values carry stimulus junk; all zero before the first patch, in the early walk steps and in the slave step
    assign {console_mode_override_en, console_master_freeze_in,
        console_hold_in, console_run_in, integ_hold_drv, integ_hold_val,
        integ_run_drv, integ_run_val} = pv;
    task automatic patch(input logic [19:0] v);
        @(posedge clk);
        pv <= v;
    endtask
endmodule // mopc_patch_model

// ==== bench/testbench.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam N_INTEG = 4;
    logic clk = 0, rst_n = 0, timer_driven_execution = 0;
    logic [1:0] panel_analog_mode = '0, timer_analog_mode = '0;
    logic [1:0] host_analog_mode = '0, sys_logic_mode_in = '0;
    logic host_analog_valid = 0, overload_in = 0, autohold_button = 0;
    logic stop_button = 0, console_logic_override_en = 0;
    logic console_halt_in = 0, console_logic_run_in = 0;
    logic console_tscale_override_en = 0;
    logic [1:0] sys_tscale_in = 2'h1, console_tscale_in = 2'h2;
    logic console_mode_override_en, console_master_freeze_in;
    logic console_hold_in, console_run_in, sys_hold_out, sys_run_out;
    logic [N_INTEG-1:0] integ_hold_drv, integ_hold_val;
    logic [N_INTEG-1:0] integ_run_drv, integ_run_val;
    logic sys_freeze_out, console_freeze_out;
    logic sys_logic_halt_out, sys_logic_run_out;
    logic [1:0] ind_analog_mode, ind_logic_mode, ind_tscale;
    logic [N_INTEG-1:0] integ_hold_out, integ_run_out;
    int err_total = 0, checks = 0;
    logic [35:0] v = 36'h1;
    wire [19:0] outs = {sys_hold_out, sys_run_out, sys_freeze_out,
        console_freeze_out, sys_logic_halt_out, sys_logic_run_out,
        ind_analog_mode, ind_logic_mode, ind_tscale, integ_hold_out,
        integ_run_out};
    mopc_mode_ctl #(.N_INTEG(N_INTEG)) u_mopc_mode_ctl (.*);
    mopc_patch_model #(.N_INTEG(N_INTEG)) u_mopc_patch_model (.*);
    initial forever #25 clk = ~clk;
    function automatic logic [1:0] fld(logic [1:0] m);
        return m[1] ? 2'h2 : m;
    endfunction
    task automatic chk(logic [19:0] got, exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic step(logic [35:0] p);
        logic [1:0] sa, ca;
        logic fr;
        logic [3:0] ih, ir;
        u_mopc_patch_model.patch(p[35:16]);
        {panel_analog_mode, timer_analog_mode, timer_driven_execution,
         host_analog_valid, host_analog_mode, sys_logic_mode_in,
         overload_in, autohold_button, stop_button,
         console_logic_override_en, console_halt_in,
         console_logic_run_in} <= p[15:0];
        sa = fld(p[10] ? p[9:8] : p[11] ? p[13:12] : p[15:14]);
        fr = p[35] ? p[34] : p[5] & p[4] | p[3] & p[11];
        ca = p[35] ? fld(p[33:32]) : sa;
        ih = fr ? 4'hF : p[31:28] & p[27:24] | ~p[31:28] & {4{ca[1]}};
        ir = (p[23:20] & p[19:16] | ~p[23:20] & {4{ca[0]}}) & ~ih;
        @(posedge clk);
        @(negedge clk);
        chk(outs, {sa, fr, fr, fld(p[7:6]), fr ? 2'h2 : ca,
            p[2] ? fld(p[1:0]) : fld(p[7:6]),
            console_tscale_override_en ? console_tscale_in : sys_tscale_in,
            ih, ir});
    endtask
    initial
    begin
        repeat (1) @(posedge clk);
        @(negedge clk);
        chk(outs, '0);
        $display("reset test done");
        @(posedge clk);
        rst_n <= 1;
        repeat (2000)
        begin
            step(v);
            v = {v[34:0], v[35] ^ v[24]};
        end
        $display("mode walk test done");
        @(posedge clk);
        console_tscale_override_en <= 1;
        // slave: master system outputs patched into console inputs
        v = {2'b10, sys_hold_out, sys_run_out, 32'h0};
        step(v);
        $display("slave test done");
        wrap_up;
    end
    initial
    begin
        #300000;
        err_total++;
        wrap_up;
    end
endmodule // testbench
